/* design/seg_display_top.sv */
`timescale 1ns/1ps
`include "seg_disp_defines.svh"

module seg_display_top (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         sys_reset,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  output logic      [19:0]                  glass_drive_output,
  output logic      [3:0]                   backplane_output,
  output logic      [1:0]                   strobe_select,
  output seg_disp_pkg::analog_ctrl_t        analog_q
);
  import seg_disp_pkg::*;

  // bus handshake state
  logic               ack_q;        // registered acknowledge
  logic               req;          // live request from the master
  logic               wr_commit;    // edge at which a write lands
  logic [31:0]        rd_word;      // read value before the flop

  // software visible state
  logic [3:0]         shared_offset_register_q;  // common slot index
  strobe_clock_ctrl_t strobe_clock_q;            // first control reg
  power_mux_ctrl_t    power_mux_q;               // second control reg

  // segment latch bank, one nibble per implemented latch
  logic [3:0]         latch_q [0:`LATCH_LAST];

  // decode results
  window_sel_t        win;          // window under the bus address
  slot_hit_t          rd_hit;       // slot decode seen by reads
  slot_hit_t          wr_hit;       // slot decode seen by writes

  // sequencer outputs
  mux_phase_t         phase;        // current multiplex phase
  logic               phase_step;   // phase advance pulse
  logic               pump_tap;     // selected divider tap

  // glass drive next values
  logic [19:0]        seg_d;        // next segment outputs
  logic [3:0]         com_d;        // next backplane outputs
  analog_ctrl_t       analog_d;     // next analog control

  // which base window an address names
  function automatic window_sel_t window_of(input logic [7:0] adr);
    window_sel_t w;
    w = WIN_NONE;
    unique case (adr)
      `OFF_WINDOW_FIRST:  w = WIN_FIRST;
      `OFF_WINDOW_SECOND: w = WIN_SECOND;
      `OFF_WINDOW_THIRD:  w = WIN_THIRD;
      default:            w = WIN_NONE;  // not a window
    endcase
    return w;
  endfunction

  // slot number from window plus index, then latch allocation;
  // the allocation is a fixed wiring choice: slot k feeds latch k
  function automatic slot_hit_t decode_slot(input window_sel_t w,
                                            input logic [3:0] idx);
    slot_hit_t  r;
    logic [5:0] slot;
    r    = '0;
    slot = 6'h00;
    unique case (w)
      WIN_THIRD:  slot = `SLOT_BASE_THIRD  + {2'b00, idx};
      WIN_SECOND: slot = `SLOT_BASE_SECOND + {2'b00, idx};
      WIN_FIRST:  slot = `SLOT_BASE_FIRST  + {2'b00, idx};
      WIN_NONE:   slot = `SLOT_COUNT;
    endcase
    // upper half of the third window has no storage at all
    if (w == WIN_THIRD && idx[3]) begin
      r.hit = 1'b0;
    end else if (slot < `LATCH_COUNT) begin
      r.hit   = 1'b1;
      r.latch = slot[4:0];
    end else begin
      r.hit = 1'b0;
    end
    return r;
  endfunction

  assign req       = wb_cyc_i & wb_stb_i;
  assign wb_ack_o  = ack_q;
  assign wr_commit = req & ack_q & wb_we_i & wb_sel_i[0];
  assign win       = window_of(wb_adr_i);
  assign rd_hit    = decode_slot(win, shared_offset_register_q);
  assign wr_hit    = decode_slot(win, shared_offset_register_q);

  // one wait state; ack drops the cycle after it is given
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read value; unmapped words and empty slots read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFF_SHARED_OFFSET: rd_word[3:0] = shared_offset_register_q;
      `OFF_STROBE_CLOCK:  rd_word[3:0] = strobe_clock_q;
      `OFF_POWER_MUX:     rd_word[3:0] = power_mux_q;
      `OFF_WINDOW_FIRST,
      `OFF_WINDOW_SECOND,
      `OFF_WINDOW_THIRD: begin
        if (rd_hit.hit) begin
          rd_word[3:0] = latch_q[rd_hit.latch];
        end
      end
      default:            rd_word = 32'h0000_0000;  // unmapped
    endcase
  end

  // read data is caught as ack rises and held until the next one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      wb_dat_o <= rd_word;
    end
  end

  // shared index; keeps its value across window accesses until rewritten or system reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_offset_register_q <= `SHARED_OFFSET_RST;
    end else if (sys_reset) begin
      shared_offset_register_q <= `SHARED_OFFSET_RST;
    end else if (wr_commit && wb_adr_i == `OFF_SHARED_OFFSET) begin
      shared_offset_register_q <= wb_dat_i[3:0];
    end
  end

  // strobe select survives system reset; pump select does not
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_clock_q <= `STROBE_CLOCK_RST;
    end else if (sys_reset) begin
      strobe_clock_q.pump_clock_select_high <= 1'b0;
      strobe_clock_q.pump_clock_select_low  <= 1'b0;
    end else if (wr_commit && wb_adr_i == `OFF_STROBE_CLOCK) begin
      strobe_clock_q <= wb_dat_i[3:0];
    end
  end

  // external bias bit keeps its value across system reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mux_q <= `POWER_MUX_RST;
    end else if (sys_reset) begin
      power_mux_q.display_blanking   <= 1'b1;
      power_mux_q.display_power_down <= 1'b1;
      power_mux_q.four_phase_select  <= 1'b1;
    end else if (wr_commit && wb_adr_i == `OFF_POWER_MUX) begin
      power_mux_q <= wb_dat_i[3:0];
    end
  end

  // latch bank; only power-on clears it, so data rides out sleep
  // and system reset just as the glass expects
  genvar g;
  generate
    for (g = 0; g < `LATCH_COUNT; g = g + 1) begin : gen_latch
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          latch_q[g] <= `LATCH_RST;
        end else if (wr_commit && win != WIN_NONE && wr_hit.hit &&
                     wr_hit.latch == 5'(g)) begin
          latch_q[g] <= wb_dat_i[3:0];
        end
      end
    end
  endgenerate

  // phase timing and pump clock taps
  seg_phase_sequencer u_seq (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .four_phase (power_mux_q.four_phase_select),
    .tap_sel    ({strobe_clock_q.pump_clock_select_high,
                  strobe_clock_q.pump_clock_select_low}),
    .phase_q    (phase),
    .phase_step (phase_step),
    .pump_tap   (pump_tap)
  );

  // segment drive: each output takes data bit n-1 in phase n
  generate
    for (g = 0; g < `LATCH_COUNT; g = g + 1) begin : gen_seg
      always_comb begin
        if (power_mux_q.display_power_down ||
            power_mux_q.display_blanking) begin
          seg_d[g] = 1'b0;
        end else if (!power_mux_q.four_phase_select &&
                     phase == PHASE_FOUR) begin
          seg_d[g] = 1'b0;  // leftover phase four shows no latch
        end else begin
          seg_d[g] = latch_q[g][phase];
        end
      end
    end
  endgenerate

  // backplanes: one hot on the phase, fourth gated in three-way mode
  always_comb begin
    com_d = 4'h0;
    if (!power_mux_q.display_power_down) begin
      unique case (phase)
        PHASE_ONE:   com_d = 4'h1;
        PHASE_TWO:   com_d = 4'h2;
        PHASE_THREE: com_d = 4'h4;
        PHASE_FOUR:  com_d = 4'h8;
      endcase
      if (!power_mux_q.four_phase_select) begin
        com_d[3] = 1'b0;
      end
    end
  end

  // pump runs unless powered down or fed from outside; blanking
  // leaves it alone so unblanking needs no settling time
  always_comb begin
    analog_d.bias_ground = power_mux_q.display_power_down;
    analog_d.pump_enable = ~power_mux_q.display_power_down &
                           ~power_mux_q.external_bias_select;
    analog_d.bias_hiz    = power_mux_q.external_bias_select &
                           ~power_mux_q.display_power_down;
    analog_d.pump_clock  = analog_d.pump_enable & pump_tap;
  end

  // registered glass and analog outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      glass_drive_output <= 20'h00000;
      backplane_output   <= 4'h0;
      analog_q           <= `ANALOG_RST;
      strobe_select      <= 2'b00;
    end else begin
      glass_drive_output <= seg_d;
      backplane_output   <= com_d;
      analog_q           <= analog_d;
      strobe_select      <= {strobe_clock_q.strobe_pin_select_high,
                             strobe_clock_q.strobe_pin_select_low};
    end
  end

  ack_one_pulse_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ack_q |=> !ack_q)
    else $error("ack held for more than one cycle");

  ack_latency_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (req && !ack_q) |=> ack_q)
    else $error("ack not given one cycle after request");

  third_high_empty_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (req && !ack_q && !wb_we_i && wb_adr_i == `OFF_WINDOW_THIRD &&
     shared_offset_register_q[3]) |=> (wb_dat_o == 32'h0000_0000))
    else $error("upper third window index returned data");

  empty_slot_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (req && !ack_q && !wb_we_i && wb_adr_i == `OFF_WINDOW_FIRST &&
     shared_offset_register_q != 4'h0) |=> (wb_dat_o == 32'h0000_0000))
    else $error("empty slot returned data");

  blank_segments_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    power_mux_q.display_blanking |=> (glass_drive_output == 20'h00000))
    else $error("segments driven while blanked");

  blank_pump_on_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (power_mux_q.display_blanking && !power_mux_q.display_power_down &&
     !power_mux_q.external_bias_select) |=> analog_q.pump_enable)
    else $error("pump stopped by blanking");

  power_down_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    power_mux_q.display_power_down |=>
    (backplane_output == 4'h0 && analog_q.bias_ground &&
     !analog_q.pump_enable))
    else $error("display active while powered down");

  backplane_phase_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!power_mux_q.display_power_down && power_mux_q.four_phase_select)
    |=> (backplane_output == (4'h1 << $past(phase))))
    else $error("backplane does not match phase");

  fourth_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !power_mux_q.four_phase_select |=> !backplane_output[3])
    else $error("fourth backplane active in three-way mode");

  sysrst_ctrl_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    sys_reset |=> (strobe_clock_q[1:0] == 2'b00 &&
                   power_mux_q[3:1] == 3'b111 &&
                   $stable(strobe_clock_q[3:2]) &&
                   $stable(power_mux_q.external_bias_select)))
    else $error("system reset effect on control bits wrong");

  phase_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!phase_step && power_mux_q.four_phase_select) |=> $stable(phase))
    else $error("phase moved between steps");

  ext_bias_hiz_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (power_mux_q.external_bias_select && !power_mux_q.display_power_down)
    |=> (analog_q.bias_hiz && !analog_q.pump_enable))
    else $error("pump running on external bias");

endmodule // seg_display_top

/* design/seg_disp_defines.svh */
`ifndef SEG_DISP_DEFINES_SVH
`define SEG_DISP_DEFINES_SVH

// bus byte offsets, one aligned 32-bit word each
`define OFF_SHARED_OFFSET   8'h00
`define OFF_WINDOW_FIRST    8'h04
`define OFF_WINDOW_SECOND   8'h08
`define OFF_WINDOW_THIRD    8'h0C
`define OFF_STROBE_CLOCK    8'h10
`define OFF_POWER_MUX       8'h14

// latch slot space: third window first, then second, then first
`define SLOT_BASE_THIRD     6'd0
`define SLOT_BASE_SECOND    6'd8
`define SLOT_BASE_FIRST     6'd24
`define SLOT_COUNT          6'd40
`define LATCH_COUNT         6'd20
`define LATCH_LAST          5'd19

// register reset values
`define STROBE_CLOCK_RST    4'h0
`define POWER_MUX_RST       4'hE
`define SHARED_OFFSET_RST   4'h0
`define LATCH_RST           4'h0
`define ANALOG_RST          4'h8

// system clock divider and its taps
`define DIV_WIDTH           9
`define DIV_RST             9'h000
`define PHASE_WRAP          8'hFF
`define TAP_BASE            4'h5

`endif

/* design/seg_disp_pkg.sv */
package seg_disp_pkg;

  // first control register, bit 3 down to bit 0
  typedef struct packed {
    logic strobe_pin_select_high;
    logic strobe_pin_select_low;
    logic pump_clock_select_high;
    logic pump_clock_select_low;
  } strobe_clock_ctrl_t;

  // second control register, bit 3 down to bit 0
  typedef struct packed {
    logic display_blanking;
    logic display_power_down;
    logic four_phase_select;
    logic external_bias_select;
  } power_mux_ctrl_t;

  // analog control lines toward bias and pump
  typedef struct packed {
    logic bias_ground;
    logic pump_enable;
    logic bias_hiz;
    logic pump_clock;
  } analog_ctrl_t;

  // multiplex phase
  typedef enum logic [1:0] {
    PHASE_ONE   = 2'b00,
    PHASE_TWO   = 2'b01,
    PHASE_THREE = 2'b10,
    PHASE_FOUR  = 2'b11
  } mux_phase_t;

  // which base window an access targets
  typedef enum logic [1:0] {
    WIN_NONE   = 2'b00,
    WIN_FIRST  = 2'b01,
    WIN_SECOND = 2'b10,
    WIN_THIRD  = 2'b11
  } window_sel_t;

  // result of slot decode
  typedef struct packed {
    logic       hit;
    logic [4:0] latch;
  } slot_hit_t;

endpackage

/* design/seg_phase_sequencer.sv */
`timescale 1ns/1ps
`include "seg_disp_defines.svh"

module seg_phase_sequencer (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    four_phase,
  input  wire logic [1:0]              tap_sel,
  output seg_disp_pkg::mux_phase_t     phase_q,
  output logic                         phase_step,
  output logic                         pump_tap
);
  import seg_disp_pkg::*;

  logic [`DIV_WIDTH-1:0] div_q;      // free-running system divider
  mux_phase_t            phase_next; // phase after a step
  logic [3:0]            tap_idx;    // divider bit picked as pump clock

  // divider runs through every reset but power-on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= `DIV_RST;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // one phase lasts two ticks of the 256 Hz display clock
  assign phase_step = (div_q[7:0] == `PHASE_WRAP);

  // tap select maps straight onto successive divider bits
  assign tap_idx  = `TAP_BASE + {2'b00, tap_sel};
  assign pump_tap = div_q[tap_idx];

  // phase order, fourth skipped in three-way mode
  always_comb begin
    unique case (phase_q)
      PHASE_ONE:   phase_next = PHASE_TWO;
      PHASE_TWO:   phase_next = PHASE_THREE;
      PHASE_THREE: phase_next = four_phase ? PHASE_FOUR
                                           : PHASE_ONE;
      PHASE_FOUR:  phase_next = PHASE_ONE;
    endcase
  end

  // leaving phase four at once keeps a mode change from stalling there
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= PHASE_ONE;
    end else if (!four_phase && phase_q == PHASE_FOUR) begin
      phase_q <= PHASE_ONE;
    end else if (phase_step) begin
      phase_q <= phase_next;
    end
  end

  no_fourth_phase_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !four_phase |=> (phase_q != PHASE_FOUR))
    else $error("fourth phase entered in three-way mode");

  phase_advance_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (phase_step && four_phase && phase_q == PHASE_ONE) |=>
    (phase_q == PHASE_TWO))
    else $error("phase did not advance on step");

endmodule // seg_phase_sequencer

/* sim/glass_model.sv */
`timescale 1ns/1ps

// passive glass: keeps the segment pattern seen under each backplane
module glass_model (
  input  wire logic             core_clk,
  input  wire logic             clear,
  input  wire logic [19:0]      seg,
  input  wire logic [3:0]       bp,
  output logic      [3:0][19:0] frame_q,
  output logic                  overlap_q,
  output logic                  bp4_q
);
  // glass only reacts where a backplane is driven, so capture per phase
  always_ff @(posedge core_clk) begin
    if (clear) begin
      frame_q   <= '0;
      overlap_q <= 1'b0;
      bp4_q     <= 1'b0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (bp[n]) begin
          frame_q[n] <= seg;
        end
      end
      // two live backplanes would light pixels of two phases at once
      if ($countones(bp) > 1) begin
        overlap_q <= 1'b1;
      end
      if (bp[3]) begin
        bp4_q <= 1'b1;
      end
    end
  end
endmodule // glass_model

/* sim/test_segment_display_latch_driver.sv */
`timescale 1ns/1ps

module test_segment_display_latch_driver;
  import seg_disp_pkg::*;

  // one bus access: direction, address, nibble (write data or expected)
  typedef struct packed {
    logic       we;
    logic [7:0] adr;
    logic [3:0] dat;
  } bus_row_t;

  logic                 core_clk;
  logic                 rst_b;
  logic                 sys_reset;
  logic                 wb_cyc_i;
  logic                 wb_stb_i;
  logic                 wb_we_i;
  logic [7:0]           wb_adr_i;
  logic [3:0]           wb_sel_i;
  logic [31:0]          wb_dat_i;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic [19:0]          glass_drive_output;
  logic [3:0]           backplane_output;
  logic [1:0]           strobe_select;
  analog_ctrl_t         analog_q;
  logic                 clear;
  logic [3:0][19:0]     frame_q;
  logic                 overlap_q;
  logic                 bp4_q;
  logic [31:0]          rd;
  logic [19:0]          exp_seg;
  int                   errors;
  int                   samples_checked;
  int                   cycles;
  int                   c;

  // index, windows, empty slots and edges of the latch slot space
  bus_row_t rows [22] = '{
    '{1'b1, 8'h00, 4'h3}, '{1'b1, 8'h08, 4'hA}, '{1'b0, 8'h08, 4'hA},
    '{1'b1, 8'h00, 4'h9}, '{1'b1, 8'h0C, 4'h5}, '{1'b0, 8'h0C, 4'h0},
    '{1'b1, 8'h04, 4'h7}, '{1'b0, 8'h04, 4'h0}, '{1'b1, 8'h00, 4'h2},
    '{1'b1, 8'h0C, 4'h9}, '{1'b0, 8'h0C, 4'h9}, '{1'b0, 8'h20, 4'h0},
    '{1'b1, 8'h10, 4'hF}, '{1'b0, 8'h10, 4'hF}, '{1'b1, 8'h14, 4'h2},
    '{1'b0, 8'h14, 4'h2}, '{1'b1, 8'h00, 4'hB}, '{1'b1, 8'h08, 4'h6},
    '{1'b0, 8'h08, 4'h6}, '{1'b1, 8'h00, 4'hC}, '{1'b1, 8'h08, 4'h5},
    '{1'b0, 8'h08, 4'h0}};

  seg_display_top seg_display_top_i (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .sys_reset          (sys_reset),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_sel_i           (wb_sel_i),
    .wb_dat_i           (wb_dat_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .glass_drive_output (glass_drive_output),
    .backplane_output   (backplane_output),
    .strobe_select      (strobe_select),
    .analog_q           (analog_q)
  );

  glass_model glass_model_i (
    .core_clk  (core_clk),
    .clear     (clear),
    .seg       (glass_drive_output),
    .bp        (backplane_output),
    .frame_q   (frame_q),
    .overlap_q (overlap_q),
    .bp4_q     (bp4_q)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      close_out();
    end
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single Wishbone cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [3:0] dat, input logic [3:0] sel);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {28'h0000000, dat};
    // only the bench timeout ends this wait
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge core_clk);
  endtask

  // cycles until the pump clock next rises
  task automatic rise(output int cnt);
    logic prev;
    cnt = 0;
    prev = 1'b1;
    while (cnt < 3000) begin
      @(posedge core_clk);
      cnt++;
      if (prev === 1'b0 && analog_q.pump_clock === 1'b1) begin
        break;
      end
      prev = analog_q.pump_clock;
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    sys_reset = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    clear = 1'b1;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    // power-on values
    bus(1'b0, 8'h10, 4'h0, 4'h1);
    chk(rd, 4'h0);
    bus(1'b0, 8'h14, 4'h0, 4'h1);
    chk(rd, 4'hE);
    chk(analog_q, 4'h8);
    chk(backplane_output, 4'h0);
    // ordinary accesses, index always loaded first
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].adr, rows[i].dat, 4'h1);
      if (!rows[i].we) begin
        chk(rd, rows[i].dat);
      end
    end
    // four-way frame: latches 2, 11, 19 hold 9, A, 6
    clear <= 1'b0;
    repeat (1100) @(posedge core_clk);
    for (int n = 0; n < 4; n++) begin
      exp_seg = 20'h00000;
      exp_seg[2] = 1'(4'h9 >> n);
      exp_seg[11] = 1'(4'hA >> n);
      exp_seg[19] = 1'(4'h6 >> n);
      chk(frame_q[n], exp_seg);
    end
    chk(overlap_q, 1'b0);
    // three-way: fourth phase and backplane unused
    bus(1'b1, 8'h14, 4'h0, 4'h1);
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    repeat (1100) @(posedge core_clk);
    chk(bp4_q, 1'b0);
    chk(frame_q[3], 20'h00000);
    chk(frame_q[0][2], 1'b1);
    // blanking: segments dark, pump still running
    bus(1'b1, 8'h14, 4'hA, 4'h1);
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    repeat (1100) @(posedge core_clk);
    for (int n = 0; n < 4; n++) begin
      chk(frame_q[n], 20'h00000);
    end
    chk(analog_q.pump_enable, 1'b1);
    // power-down, then external bias
    bus(1'b1, 8'h14, 4'h4, 4'h1);
    repeat (3) @(posedge core_clk);
    chk(analog_q, 4'h8);
    chk(backplane_output, 4'h0);
    bus(1'b1, 8'h14, 4'h3, 4'h1);
    repeat (3) @(posedge core_clk);
    chk(analog_q.bias_hiz, 1'b1);
    // system reset keeps strobe, bias select and latches
    @(posedge core_clk);
    sys_reset <= 1'b1;
    @(posedge core_clk);
    sys_reset <= 1'b0;
    bus(1'b0, 8'h10, 4'h0, 4'h1);
    chk(rd, 4'hC);
    chk(strobe_select, 2'b11);
    bus(1'b0, 8'h14, 4'h0, 4'h1);
    chk(rd, 4'hF);
    bus(1'b1, 8'h00, 4'h2, 4'h1);
    bus(1'b1, 8'h0C, 4'h3, 4'h0);
    bus(1'b0, 8'h0C, 4'h0, 4'h1);
    chk(rd, 4'h9);
    // pump clock tap per select value
    bus(1'b1, 8'h14, 4'h2, 4'h1);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h10, s[3:0], 4'h1);
      rise(c);
      rise(c);
      chk(c, 32'd1 << (6 + s));
    end
    // power-on reset mid-run clears what system reset keeps
    bus(1'b1, 8'h10, 4'hF, 4'h1);
    bus(1'b1, 8'h14, 4'h1, 4'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    bus(1'b0, 8'h10, 4'h0, 4'h1);
    chk(rd, 4'h0);
    bus(1'b0, 8'h14, 4'h0, 4'h1);
    chk(rd, 4'hE);
    close_out();
  end
endmodule // test_segment_display_latch_driver
